// ===== src/byte_word_decrement_unit.v
// execution datapath for byte and word decrement with apb control
`timescale 1ns/10ps
`default_nettype none
`include "byte_word_decrement_defines.vh"

module byte_word_decrement_unit (
   input wire clock,
   input wire resetn,
   // decoded instruction
   input wire start,
   input wire [7:0] opcode,
   input wire [7:0] dst_addr,
   output reg busy,
   output reg done,
   // register file, combinational read
   output reg [7:0] rf_raddr,
   input wire [7:0] rf_rdata,
   output reg rf_we,
   output reg [7:0] rf_waddr,
   output reg [7:0] rf_wdata,
   // condition byte update
   output reg flags_we,
   output reg [7:0] flags_wdata,
   output reg [7:0] flags_wmask,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr
);
   localparam ST_IDLE = 3'd0;
   localparam ST_PTR = 3'd1;
   localparam ST_RD_A = 3'd2;
   localparam ST_RD_B = 3'd3;
   localparam ST_CALC = 3'd4;
   localparam ST_WB2 = 3'd5;
   localparam ST_WAIT = 3'd6;
   localparam ST_FIN = 3'd7;

   reg [2:0] state_reg;
   reg [3:0] cnt_reg;
   reg [3:0] last_reg;
   reg word_reg;
   reg ptr_reg;
   reg [7:0] ea_reg;
   reg [7:0] opa_reg;
   reg [7:0] opb_reg;
   reg [31:0] ctrl_reg;
   reg refused_reg;
   reg [15:0] result_reg;
   reg [7:0] res_flags_reg;
   reg [15:0] count_reg;

   wire [15:0] core_result;
   wire core_zero;
   wire core_sign;
   wire core_ovf;
   wire legal_op;
   wire op_word;
   wire op_ptr;
   wire apb_setup;
   wire apb_write;
   wire [7:0] calc_flags;

   // returns 1 for an offset that maps a register
   function mapped;
      input [11:0] a;
      begin
         mapped = (a == `OFS_CTRL) || (a == `OFS_STATUS) ||
            (a == `OFS_RESULT) || (a == `OFS_COUNT);
      end
   endfunction

   // opcode decode: bit 7 picks word, bit 0 picks pointer operand
   assign legal_op = (opcode == `OPC_BYTE_REG) || (opcode == `OPC_BYTE_PTR) ||
      (opcode == `OPC_WORD_PAIR) || (opcode == `OPC_WORD_PTR);
   assign op_word = opcode[7];
   assign op_ptr = opcode[0];
   assign apb_setup = psel & ~penable;
   assign apb_write = psel & penable & pready & pwrite;
   // fresh flag byte; c, d and h positions stay zero and are masked off
   assign calc_flags = ({7'h00, core_zero} << `FLAG_Z) |
      ({7'h00, core_sign} << `FLAG_S) | ({7'h00, core_ovf} << `FLAG_V);

   // byte operand is passed as the low byte
   decrement_core decrement_core_inst (
      .word_mode(word_reg),
      .hi_byte(word_reg ? opa_reg : 8'h00),
      .lo_byte(word_reg ? opb_reg : opa_reg),
      .result(core_result),
      .zero(core_zero),
      .sign(core_sign),
      .overflow(core_ovf)
   );

   // instruction sequencer; done lands in the last cycle of the budget
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
         last_reg <= 4'h0;
         word_reg <= 1'b0;
         ptr_reg <= 1'b0;
         ea_reg <= 8'h00;
         opa_reg <= 8'h00;
         opb_reg <= 8'h00;
         busy <= 1'b0;
         done <= 1'b0;
         rf_raddr <= 8'h00;
         rf_we <= 1'b0;
         rf_waddr <= 8'h00;
         rf_wdata <= 8'h00;
         flags_we <= 1'b0;
         flags_wdata <= 8'h00;
         flags_wmask <= 8'h00;
         refused_reg <= 1'b0;
         result_reg <= 16'h0000;
         res_flags_reg <= 8'h00;
         count_reg <= 16'h0000;
      end else begin
         rf_we <= 1'b0;
         done <= 1'b0;
         flags_we <= 1'b0;
         if (state_reg != ST_IDLE)
            cnt_reg <= cnt_reg + 4'h1;
         case (state_reg)
            ST_IDLE: begin
               if (start) begin
                  // a start while disabled or with a foreign opcode is dropped
                  if (legal_op && ctrl_reg[`CTRL_ENABLE]) begin
                     refused_reg <= 1'b0;
                     busy <= 1'b1;
                     cnt_reg <= 4'h0;
                     word_reg <= op_word;
                     ptr_reg <= op_ptr;
                     ea_reg <= dst_addr;
                     rf_raddr <= dst_addr;
                     // budget minus two: done is registered one cycle late
                     last_reg <= op_word ? `CYCLES_WORD - 4'h2 :
                        `CYCLES_BYTE - 4'h2;
                     state_reg <= op_ptr ? ST_PTR : ST_RD_A;
                  end else begin
                     refused_reg <= 1'b1;
                  end
               end
            end
            ST_PTR: begin
               // named register holds the operand address
               ea_reg <= rf_rdata;
               rf_raddr <= rf_rdata;
               state_reg <= ST_RD_A;
            end
            ST_RD_A: begin
               opa_reg <= rf_rdata;
               if (word_reg) begin
                  // odd pointers are not corrected; software keeps them even
                  rf_raddr <= ea_reg + 8'h01;
                  state_reg <= ST_RD_B;
               end else begin
                  state_reg <= ST_CALC;
               end
            end
            ST_RD_B: begin
               opb_reg <= rf_rdata;
               state_reg <= ST_CALC;
            end
            ST_CALC: begin
               // first write: the lone byte, or the low byte of the pair
               rf_we <= 1'b1;
               rf_waddr <= word_reg ? ea_reg + 8'h01 : ea_reg;
               rf_wdata <= core_result[7:0];
               result_reg <= core_result;
               res_flags_reg <= calc_flags;
               state_reg <= word_reg ? ST_WB2 : ST_WAIT;
            end
            ST_WB2: begin
               // high byte goes back to the even address
               rf_we <= 1'b1;
               rf_waddr <= ea_reg;
               rf_wdata <= result_reg[15:8];
               state_reg <= ST_WAIT;
            end
            ST_WAIT: begin
               state_reg <= ST_WAIT;
            end
            ST_FIN: begin
               busy <= 1'b0;
               state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
         // end of budget; zero flag after a word op covers all sixteen bits
         // of the result, so it matches a nor of the two bytes
         if (state_reg != ST_IDLE && state_reg != ST_FIN &&
               cnt_reg == last_reg) begin
            done <= 1'b1;
            flags_we <= 1'b1;
            // c, d and h are outside the mask and so stay untouched
            flags_wmask <= (8'h01 << `FLAG_Z) | (8'h01 << `FLAG_S) |
               (8'h01 << `FLAG_V);
            // pointer byte form ends in its calc cycle: take fresh flags
            flags_wdata <= (state_reg == ST_CALC) ? calc_flags : res_flags_reg;
            count_reg <= count_reg + 16'h0001;
            state_reg <= ST_FIN;
         end
      end
   end

   // apb slave: zero wait states, read data captured in the setup cycle
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ctrl_reg <= `CTRL_RESET;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= apb_setup;
         pslverr <= apb_setup & ~mapped(paddr);
         if (apb_setup && !pwrite) begin
            case (paddr)
               `OFS_CTRL: prdata <= ctrl_reg;
               `OFS_STATUS: prdata <= {29'h00000000, word_reg,
                  refused_reg, busy};
               `OFS_RESULT: prdata <= {8'h00, res_flags_reg, result_reg};
               `OFS_COUNT: prdata <= {16'h0000, count_reg};
               default: prdata <= 32'h00000000;
            endcase
         end
         // only the enable bit is writable
         if (apb_write && paddr == `OFS_CTRL)
            ctrl_reg <= {31'h00000000, pwdata[`CTRL_ENABLE]};
      end
   end
endmodule // byte_word_decrement_unit

`default_nettype wire

// ===== inc/byte_word_decrement_defines.vh
// constants for the byte and word decrement datapath
`ifndef BYTE_WORD_DECREMENT_DEFINES_VH
`define BYTE_WORD_DECREMENT_DEFINES_VH

// instruction opcodes
`define OPC_BYTE_REG 8'h00
`define OPC_BYTE_PTR 8'h01
`define OPC_WORD_PAIR 8'h80
`define OPC_WORD_PTR 8'h81

// instruction lengths in core clock cycles
`define CYCLES_BYTE 4'h4
`define CYCLES_WORD 4'h8

// condition byte bit positions
`define FLAG_C 7
`define FLAG_Z 6
`define FLAG_S 5
`define FLAG_V 4
`define FLAG_D 3
`define FLAG_H 2

// apb register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_RESULT 12'h008
`define OFS_COUNT 12'h00c

// control register fields and reset value
`define CTRL_ENABLE 0
`define CTRL_RESET 32'h00000001

// status register fields
`define STAT_BUSY 0
`define STAT_REFUSED 1
`define STAT_WORD 2

`endif

// ===== src/decrement_core.v
// combinational subtract-one and flag generation for byte or word
`timescale 1ns/10ps
`default_nettype none

module decrement_core (
   input wire word_mode,
   input wire [7:0] hi_byte,
   input wire [7:0] lo_byte,
   output wire [15:0] result,
   output wire zero,
   output wire sign,
   output wire overflow
);
   wire [15:0] word_in;
   wire [7:0] byte_res;
   wire [15:0] word_res;

   // high byte sits at the even address, borrow runs from low into high
   assign word_in = {hi_byte, lo_byte};
   assign word_res = word_in - 16'h0001;
   // byte operand travels in lo_byte; wraps 00h to ffh
   assign byte_res = lo_byte - 8'h01;
   assign result = word_mode ? word_res : {8'h00, byte_res};
   assign zero = word_mode ? (word_res == 16'h0000) :
      (byte_res == 8'h00);
   // byte form clears sign; word form takes the result msb
   assign sign = word_mode & word_res[15];
   // only 8000h minus one overflows; byte form leaves v undefined, drive 0
   assign overflow = word_mode & (word_in == 16'h8000);
endmodule // decrement_core

`default_nettype wire

// ===== tb/byte_word_decrement_unit_sva.sv
// port assertions for the byte and word decrement unit
`timescale 1ns/10ps
`default_nettype none
module byte_word_decrement_unit_sva (
   input wire clock,
   input wire resetn,
   input wire start,
   input wire [7:0] opcode,
   input wire busy,
   input wire done,
   input wire rf_we,
   input wire flags_we,
   input wire [7:0] flags_wmask,
   input wire psel,
   input wire penable,
   input wire pready
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // accepted starts split by width; a dropped start never raises busy
   sequence take_byte;
      !busy && start && opcode[7:1] == 7'h00 ##1 busy;
   endsequence
   sequence take_word;
      !busy && start && opcode[7:1] == 7'h40 ##1 busy;
   endsequence
   sequence byte_run; !done [*3] ##1 done; endsequence
   sequence word_run; !done [*7] ##1 done; endsequence
   a_byte_length: assert property (take_byte |-> byte_run)
      else $error("byte decrement length wrong");
   a_word_length: assert property (take_word |-> word_run)
      else $error("word decrement length wrong");
   a_byte_busy: assert property (take_byte |-> busy [*4] ##1 !busy)
      else $error("busy span wrong for byte form");
   a_word_busy: assert property (take_word |-> busy [*8] ##1 !busy)
      else $error("busy span wrong for word form");
   a_flags_done: assert property (done |->
      flags_we && flags_wmask == 8'h70)
      else $error("flag update missing or wrong mask");
   a_done_pulse: assert property (done |=> !done && !flags_we)
      else $error("done longer than one cycle");
   a_write_busy: assert property (rf_we |-> busy)
      else $error("write-back outside an instruction");
   a_busy_release: assert property ($fell(busy) |-> $past(done))
      else $error("busy fell without done");
   a_apb_answer: assert property (psel && !penable |=> pready)
      else $error("apb access not answered at once");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
endmodule // byte_word_decrement_unit_sva
bind byte_word_decrement_unit byte_word_decrement_unit_sva
   byte_word_decrement_unit_sva_inst (.clock(clock), .resetn(resetn),
   .start(start), .opcode(opcode), .busy(busy), .done(done),
   .rf_we(rf_we), .flags_we(flags_we), .flags_wmask(flags_wmask),
   .psel(psel), .penable(penable), .pready(pready));
`default_nettype wire

// ===== tb/byte_word_decrement_unit_tb.sv
// self-checking bench for the byte and word decrement unit
`timescale 1ns/10ps
`default_nettype none
`include "byte_word_decrement_defines.vh"
`define check_eq(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
   $display("ERROR %0t got %h want %h", $time, a, b); end end
module byte_word_decrement_unit_tb;
   typedef struct {logic w; logic [7:0] a; logic [15:0] v;
      logic [7:0] f;} note_t;
   logic clock = 1'b0, resetn = 1'b0, start = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
   logic [7:0] opcode = 8'h00, dst_addr = 8'h00, rf_raddr, rf_waddr, rf_wdata;
   logic [7:0] fw, fm, d, op, mem [0:255];
   logic busy, done, rf_we, flags_we, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [15:0] last;
   logic en = 1'b1;
   logic [7:0] byte_vals [0:2] = '{8'h00, 8'h01, 8'h80};
   logic [15:0] word_vals [0:4] = '{16'h1234, 16'h0000, 16'h8000, 16'h0001,
      16'h0100};
   note_t exp_q[$];
   int fails = 0, tests_run = 0, ndone = 0;
   wire [7:0] rf_rdata = mem[rf_raddr];
   byte_word_decrement_unit byte_word_decrement_unit_inst (.clock(clock),
      .resetn(resetn), .start(start), .opcode(opcode), .dst_addr(dst_addr),
      .busy(busy), .done(done), .rf_raddr(rf_raddr), .rf_rdata(rf_rdata),
      .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata),
      .flags_we(flags_we), .flags_wdata(fw), .flags_wmask(fm), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   always #5 clock = ~clock;
   // register file: combinational read, write on the strobe
   always @(posedge clock) if (rf_we) mem[rf_waddr] <= rf_wdata;
   // pair each done pulse with the oldest note; memory checked once settled
   always @(negedge clock) if (done === 1'b1) begin
      note_t n;
      if (exp_q.size() == 0) `check_eq(1'b1, 1'b0)
      else begin
         n = exp_q.pop_front();
         `check_eq(fw & fm, n.f)
         @(posedge clock);
         #1;
         if (n.w) begin
            `check_eq({mem[n.a], mem[n.a + 8'h01]}, n.v)
            `check_eq(~|{mem[n.a], mem[n.a + 8'h01]}, fw[`FLAG_Z])
         end else
            `check_eq(mem[n.a], n.v[7:0])
      end
   end
   // apb master: request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] v);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so the next call never re-drives psel in this step
      @(posedge clock);
   endtask
   // start is held two edges: the second falls while busy and must be ignored
   task automatic run(input logic [7:0] o, input logic [7:0] t);
      note_t n;
      logic [15:0] x;
      n.w = o[7];
      n.a = o[0] ? mem[t] : t;
      x = o[7] ? {mem[n.a], mem[n.a + 8'h01]} : {8'h00, mem[n.a]};
      n.v = o[7] ? x - 16'h0001 : {8'h00, x[7:0] - 8'h01};
      n.f = {1'b0, n.v == 16'h0000, o[7] & n.v[15], o[7] & (x == 16'h8000),
         4'h0};
      if (o[6:1] == 6'h00 && en) begin
         exp_q.push_back(n);
         ndone++;
         last = n.v;
      end
      start <= 1'b1; opcode <= o; dst_addr <= t;
      repeat (2) @(posedge clock);
      start <= 1'b0;
      repeat (2) @(negedge clock);
      while (busy !== 1'b0) @(negedge clock);
      @(posedge clock);
   endtask
   task automatic tally_and_finish;
      $display("tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(22785));
      foreach (mem[i]) mem[i] = 8'($urandom);
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      apb(1'b0, `OFS_CTRL, 32'h0);
      `check_eq(q, `CTRL_RESET)
      mem[8'h01] = 8'h03;
      mem[8'h03] = 8'h10;
      run(`OPC_BYTE_PTR, 8'h01);
      run(`OPC_BYTE_REG, 8'h01);
      foreach (byte_vals[i]) begin
         mem[8'h05] = byte_vals[i];
         run(`OPC_BYTE_REG, 8'h05);
      end
      // word edge values: plain, zero wrap, overflow, zero result, borrow
      foreach (word_vals[i]) begin
         {mem[8'h10], mem[8'h11]} = word_vals[i];
         run(`OPC_WORD_PAIR, 8'h10);
      end
      mem[8'h02] = 8'h30;
      run(`OPC_WORD_PTR, 8'h02);
      for (int i = 0; i < 24; i++) begin
         op = ($urandom_range(1, 0) != 0) ? 8'h80 : 8'h00;
         op[0] = 1'($urandom_range(1, 0));
         d = 8'($urandom);
         if (op == `OPC_WORD_PAIR) d[0] = 1'b0;
         if (op == `OPC_WORD_PTR) mem[d][0] = 1'b0;
         run(op, d);
      end
      apb(1'b0, `OFS_RESULT, 32'h0);
      `check_eq(q[15:0], last)
      apb(1'b0, `OFS_COUNT, 32'h0);
      `check_eq(q[15:0], ndone[15:0])
      run(8'h40, 8'h05);
      apb(1'b0, `OFS_STATUS, 32'h0);
      `check_eq(q[1:0], 2'b10)
      apb(1'b0, 12'h010, 32'h0);
      `check_eq({e, q}, {1'b1, 32'h0})
      apb(1'b1, `OFS_STATUS, 32'hffffffff);
      `check_eq(e, 1'b0)
      // disabled: a legal start is dropped and never counted
      apb(1'b1, `OFS_CTRL, 32'h0);
      en = 1'b0;
      run(`OPC_BYTE_REG, 8'h05);
      apb(1'b0, `OFS_COUNT, 32'h0);
      `check_eq(q[15:0], ndone[15:0])
      apb(1'b1, `OFS_CTRL, 32'h1);
      `check_eq(e, 1'b0)
      en = 1'b1;
      run(`OPC_BYTE_REG, 8'h05);
      repeat (4) @(posedge clock);
      `check_eq(exp_q.size(), 0)
      tally_and_finish();
   end
endmodule // byte_word_decrement_unit_tb
`default_nettype wire
